// file: rtl/esp_pkg.sv
/*
 * Package for the configuration memory access block: register offsets, field
 * positions, reset values, the state enum and the carrier structs.
 * Assumes a 16-bit register port with byte-wide addresses.
 */
package esp_pkg;

    localparam logic [7:0]  ADDR_KEY       = 8'h31;
    localparam logic [7:0]  ADDR_STATUS    = 8'h32;
    localparam logic [7:0]  ADDR_IND_ADDR  = 8'h33;
    localparam logic [7:0]  ADDR_IND_WDATA = 8'h34;
    localparam logic [7:0]  ADDR_ACC_CTRL  = 8'h35;
    localparam logic [7:0]  ADDR_IND_RDATA = 8'h36;
    localparam logic [7:0]  ADDR_UNUSED0_LO = 8'h37;
    localparam logic [7:0]  ADDR_UNUSED0_HI = 8'h5F;
    localparam logic [7:0]  ADDR_MOTOR_DIS = 8'h60;
    localparam logic [7:0]  ADDR_UNUSED1_LO = 8'h61;
    localparam logic [7:0]  ADDR_UNUSED1_HI = 8'h8F;
    localparam logic [7:0]  ADDR_CFG_FIRST = 8'h90;
    localparam logic [7:0]  ADDR_CFG_LAST  = 8'h96;
    localparam int          CFG_WORDS      = 7;

    localparam int          BIT_SHADOW     = 12;
    localparam int          BIT_RESYNC     = 8;
    localparam int          BIT_DIRECTION  = 2;
    localparam int          BIT_INHIBIT    = 15;
    localparam int          BIT_READY      = 0;

    localparam logic [1:0]  KIND_OFF       = 2'b00;
    localparam logic [1:0]  KIND_SINGLE    = 2'b01;
    localparam logic [1:0]  KIND_MASS      = 2'b10;

    localparam logic [15:0] UNLOCK_KEY     = 16'hC0DE;
    localparam logic [15:0] RESET_WORD     = 16'h0000;

    typedef enum logic [1:0]
    {
        ESP_IDLE = 2'b00,
        ESP_BUSY = 2'b01
    } esp_state_e;

    // First configuration word as seen by the motor control.
    typedef struct packed
    {
        logic [1:0] spread_spectrum_sel;
        logic [1:0] tach_openloop_sel;
        logic [3:0] tach_divider;
        logic       clock_trim_step;
        logic [2:0] resistance_shift;
        logic [3:0] resistance_mantissa;
    } esp_cfg1_s;

    // Register port from the serial interface.
    typedef struct packed
    {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } esp_req_s;

endpackage

// file: rtl/esp_ctrl.sv
/*
 * Configuration memory access controller with shadow registers, single and
 * mass transfers, a resync from memory and the drive inhibit bit.
 * Assumes the serial slave presents one-cycle read and write strobes and the
 * memory answers each held request with a one-cycle acknowledge.
 */
//
// Operation
// - Shadow select low: shadow values unused.
// - Shadow select high: run and read shadows.
// - Resync bit copies memory into shadows.
// - Direction bit: zero reads, one writes.
// - Access kind: off, single, mass, reserved.
// - Single read value holds last word fetched by a single read.
// - Offsets 0x37 to 0x5F are unused.
// - Drive inhibit bit is write only.
// - Drive inhibit stops motor, resets to zero.
// - Offsets 0x61 to 0x8F are unused.
// - Config word one field layout, reset zero.
// - Ready flag reports memory ready for access.
// - Single access address selects memory location.
// - Single write value supplies written word.
`timescale 1ns/1ps
`default_nettype none

module esp_ctrl
    import esp_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Register port.
    input  wire esp_req_s   reg_req,
    output logic [15:0]     reg_rdata,
    output logic            reg_rvalid,
    // Memory port.
    output logic            nvm_req,
    output logic            nvm_we,
    output logic [7:0]      nvm_addr,
    output logic [15:0]     nvm_wdata,
    input  wire logic [15:0] nvm_rdata,
    input  wire logic       nvm_ack,
    // Motor control side.
    output esp_cfg1_s       cfg_word_one,
    output logic            shadow_in_use,
    output logic            drive_inhibit
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed
    {
        esp_state_e                state;
        logic                      op_resync;
        logic                      op_mass;
        logic                      op_we;
        logic [2:0]                idx;
        logic [7:0]                mem_addr;
        logic [15:0]               mem_wdata;
        logic [15:0]               key;
        logic [7:0]                single_access_addr;
        logic [15:0]               single_write_value;
        logic [15:0]               single_read_value;
        logic                      shadow_select;
        logic                      nvm_resync;
        logic                      nvm_direction;
        logic [1:0]                nvm_access_kind;
        logic                      drive_inhibit;
        logic [CFG_WORDS-1:0][15:0] cfg;
        logic [CFG_WORDS-1:0][15:0] shadow;
        logic [15:0]               active;
        logic [15:0]               rdata;
        logic                      rvalid;
    } esp_ctrl_s;

    esp_ctrl_s q;
    esp_ctrl_s d;

    logic       cfg_hit;
    logic [2:0] cfg_idx;
    logic       unlocked;
    logic       resync_set;

    assign cfg_hit  = (reg_req.addr >= ADDR_CFG_FIRST) && (reg_req.addr <= ADDR_CFG_LAST);
    assign cfg_idx  = 3'(reg_req.addr - ADDR_CFG_FIRST);
    assign unlocked = (q.key == UNLOCK_KEY);
    assign resync_set = reg_req.wr && (reg_req.addr == ADDR_ACC_CTRL) && reg_req.wdata[BIT_RESYNC];

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        d        = q;
        d.rvalid = 1'b0;
        // Register writes; unmapped offsets are ignored.
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                ADDR_KEY:       d.key = reg_req.wdata;
                ADDR_IND_ADDR:  d.single_access_addr = reg_req.wdata[7:0];
                ADDR_IND_WDATA: d.single_write_value = reg_req.wdata;
                ADDR_ACC_CTRL:
                begin
                    d.shadow_select   = reg_req.wdata[BIT_SHADOW];
                    d.nvm_direction   = reg_req.wdata[BIT_DIRECTION];
                    d.nvm_access_kind = reg_req.wdata[1:0];
                    if (reg_req.wdata[BIT_RESYNC])
                    begin
                        d.nvm_resync = 1'b1;
                    end
                end
                ADDR_MOTOR_DIS: d.drive_inhibit = reg_req.wdata[BIT_INHIBIT];
                default:
                begin
                    if (cfg_hit && unlocked)
                    begin
                        if (q.shadow_select)
                        begin
                            d.shadow[cfg_idx] = reg_req.wdata;
                        end
                        else
                        begin
                            d.cfg[cfg_idx] = reg_req.wdata;
                        end
                    end
                end
            endcase
        end
        // Register reads; unused offsets and the inhibit word read zero.
        if (reg_req.rd)
        begin
            d.rvalid = 1'b1;
            case (reg_req.addr)
                ADDR_KEY:       d.rdata = q.key;
                ADDR_STATUS:    d.rdata = {15'h0000, q.state == ESP_IDLE};
                ADDR_IND_ADDR:  d.rdata = {8'h00, q.single_access_addr};
                ADDR_IND_WDATA: d.rdata = q.single_write_value;
                ADDR_ACC_CTRL:  d.rdata = {3'b000, q.shadow_select, 3'b000, q.nvm_resync,
                                           5'b0_0000, q.nvm_direction, q.nvm_access_kind};
                ADDR_IND_RDATA: d.rdata = q.single_read_value;
                ADDR_MOTOR_DIS: d.rdata = RESET_WORD;
                default:
                begin
                    if (cfg_hit && unlocked)
                    begin
                        d.rdata = q.shadow_select ? q.shadow[cfg_idx] : q.cfg[cfg_idx];
                    end
                    else
                    begin
                        d.rdata = RESET_WORD;
                    end
                end
            endcase
        end
        // Memory transfer sequencer.
        case (q.state)
            ESP_IDLE:
            begin
                d.idx = 3'd0;
                if (q.nvm_resync)
                begin
                    d.state     = ESP_BUSY;
                    d.op_resync = 1'b1;
                    d.op_mass   = 1'b1;
                    d.op_we     = 1'b0;
                    d.mem_addr  = ADDR_CFG_FIRST;
                end
                else if (reg_req.wr && reg_req.addr == ADDR_ACC_CTRL
                         && (reg_req.wdata[1:0] == KIND_SINGLE
                             || reg_req.wdata[1:0] == KIND_MASS))
                begin
                    d.state     = ESP_BUSY;
                    d.op_resync = 1'b0;
                    d.op_mass   = reg_req.wdata[1];
                    d.op_we     = reg_req.wdata[BIT_DIRECTION];
                    d.mem_addr  = reg_req.wdata[1] ? ADDR_CFG_FIRST : q.single_access_addr;
                    d.mem_wdata = reg_req.wdata[1] ? q.cfg[0] : q.single_write_value;
                end
            end
            ESP_BUSY:
            begin
                if (nvm_ack)
                begin
                    if (!q.op_we)
                    begin
                        if (q.op_resync)
                        begin
                            d.shadow[q.idx] = nvm_rdata;
                        end
                        else if (q.op_mass)
                        begin
                            d.cfg[q.idx] = nvm_rdata;
                        end
                        else
                        begin
                            d.single_read_value = nvm_rdata;
                        end
                    end
                    if (q.op_mass && q.idx != 3'(CFG_WORDS - 1))
                    begin
                        d.idx       = q.idx + 3'd1;
                        d.mem_addr  = q.mem_addr + 8'd1;
                        d.mem_wdata = q.cfg[q.idx + 3'd1];
                    end
                    else
                    begin
                        d.state = ESP_IDLE;
                        // A resync request written in the final cycle wins over the clear.
                        if (q.op_resync && !resync_set)
                        begin
                            d.nvm_resync = 1'b0;
                        end
                    end
                end
            end
            default: d.state = ESP_IDLE;
        endcase
        d.active = d.shadow_select ? d.shadow[0] : d.cfg[0];
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign reg_rdata     = q.rdata;
    assign reg_rvalid    = q.rvalid;
    assign nvm_req       = (q.state == ESP_BUSY);
    assign nvm_we        = q.op_we;
    assign nvm_addr      = q.mem_addr;
    assign nvm_wdata     = q.mem_wdata;
    assign cfg_word_one  = esp_cfg1_s'(q.active);
    assign shadow_in_use = q.shadow_select;
    assign drive_inhibit = q.drive_inhibit;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    inhibit_write_a: assert property (
        reg_req.wr && reg_req.addr == ADDR_MOTOR_DIS
        |=> drive_inhibit == $past(reg_req.wdata[BIT_INHIBIT]))
        else $error("Drive inhibit did not follow its write.");

    inhibit_hidden_a: assert property (
        reg_req.rd && reg_req.addr == ADDR_MOTOR_DIS |=> reg_rvalid && reg_rdata == 16'h0000)
        else $error("Inhibit word read back nonzero.");

    unused_low_a: assert property (
        reg_req.rd && reg_req.addr >= 8'h37 && reg_req.addr <= 8'h5F |=> reg_rdata == 16'h0000)
        else $error("Unused low offset read nonzero.");

    unused_high_a: assert property (
        reg_req.rd && reg_req.addr >= 8'h61 && reg_req.addr <= 8'h8F |=> reg_rdata == 16'h0000)
        else $error("Unused high offset read nonzero.");

    shadow_drive_a: assert property (
        q.shadow_select && $stable(q.shadow_select) && $stable(q.shadow[0])
        |-> cfg_word_one == esp_cfg1_s'(q.shadow[0]))
        else $error("Motor config not taken from shadow.");

    normal_drive_a: assert property (
        !q.shadow_select && $stable(q.shadow_select) && $stable(q.cfg[0])
        |-> cfg_word_one == esp_cfg1_s'(q.cfg[0]))
        else $error("Shadow used while deselected.");

    busy_flag_a: assert property (
        (q.state == ESP_IDLE && !q.nvm_resync && reg_req.wr && reg_req.addr == ADDR_ACC_CTRL
        && reg_req.wdata[1:0] == KIND_SINGLE) ##1 (nvm_req && !nvm_ack)
        ##1 (reg_req.rd && reg_req.addr == ADDR_STATUS) |=> reg_rdata[0] == 1'b0)
        else $error("Ready flag high during transfer.");

    single_read_a: assert property (
        nvm_req && nvm_ack && !q.op_mass && !q.op_we |=> q.single_read_value == $past(nvm_rdata))
        else $error("Single read value not captured.");

    resync_copy_a: assert property (
        nvm_req && nvm_ack && q.op_resync |=> q.shadow[$past(q.idx)] == $past(nvm_rdata))
        else $error("Resync word not copied to shadow.");

    resync_cov: cover property (nvm_req && nvm_ack && q.op_resync && q.idx == 3'd6);
    single_write_cov: cover property (nvm_req && nvm_we && nvm_ack && !q.op_mass);
    mass_read_cov: cover property (nvm_req && !nvm_we && nvm_ack && q.op_mass && !q.op_resync);

endmodule

`default_nettype wire

// file: testbench/esp_nvm_model.sv
/*
 * Behavioural configuration memory on the controller's memory port.
 * Assumes one request at a time, held high until it is acknowledged.
 */
`timescale 1ns/1ps
`default_nettype none

module esp_nvm_model
    import esp_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Memory port.
    input  wire logic        nvm_req,
    input  wire logic        nvm_we,
    input  wire logic [7:0]  nvm_addr,
    input  wire logic [15:0] nvm_wdata,
    output logic      [15:0] nvm_rdata,
    output logic             nvm_ack,
    // Answer delay in cycles.
    input  wire logic [2:0]  answer_delay
);
    logic [15:0] cells [256];
    logic [2:0]  wait_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read data is valid only with the acknowledge; otherwise it toggles.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            nvm_ack   <= 1'b0;
            wait_q    <= 3'h0;
            nvm_rdata <= 16'hFFFF;
        end
        else
        begin
            nvm_ack   <= 1'b0;
            nvm_rdata <= ~nvm_rdata;
            if (nvm_req && !nvm_ack)
            begin
                if (wait_q >= answer_delay)
                begin
                    nvm_ack   <= 1'b1;
                    wait_q    <= 3'h0;
                    nvm_rdata <= cells[nvm_addr];
                    if (nvm_we)
                        cells[nvm_addr] <= nvm_wdata;
                end
                else
                    wait_q <= wait_q + 3'h1;
            end
        end
    end

endmodule

`default_nettype wire

// file: testbench/testbench.sv
/*
 * Self-checking bench for the configuration memory access controller.
 * Assumes the controller faces the behavioural memory model.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import esp_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    esp_req_s    req = '0;
    logic [15:0] rdata, nvm_rdata, nvm_wdata, got, val, old;
    logic        rvalid, nvm_req, nvm_we, nvm_ack, shadow, inhibit;
    logic [7:0]  nvm_addr;
    esp_cfg1_s   cfg1;
    logic [2:0]  delay = 3'h0;
    logic [15:0] lfsr_q = 16'h8243;
    logic [7:0]  holes [4] = '{8'h37, 8'h5F, 8'h61, 8'h8F};
    int          ack_exp [4] = '{0, 1, 7, 0};
    int          err_total = 0, checks_done = 0, acks = 0, cycles = 0;
    int          ref_mem [256];

    esp_ctrl esp_ctrl_i (.clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .nvm_req(nvm_req), .nvm_we(nvm_we), .nvm_addr(nvm_addr),
        .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack),
        .cfg_word_one(cfg1), .shadow_in_use(shadow), .drive_inhibit(inhibit));
    esp_nvm_model esp_nvm_model_i (.clk_sys(clk_sys), .rst(rst), .nvm_req(nvm_req),
        .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .nvm_ack(nvm_ack), .answer_delay(delay));

    ////////////////////////////////////////////////////////////////////////////
    always #12.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
    begin
        cycles++;
        if (nvm_ack === 1'b1)
            acks++;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic test_done();
        $display("Checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        #2;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        #2;
        req.wr = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        #2;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: lfsr_q};
        @(posedge clk_sys);
        #2;
        req.rd = 1'b0;
        chk("rvalid", {15'h0, rvalid}, 16'h0001);
        d = rdata;
    endtask

    task automatic wait_ready();
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 100; i++)
        begin
            reg_rd(ADDR_STATUS, got);
            if (got[0] === 1'b1)
                break;
        end
        chk("ready", got, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        for (int a = 0; a < 256; a++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            ref_mem[a] = lfsr_q;
            esp_nvm_model_i.cells[a] = lfsr_q;
        end
        repeat (8) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        chk("inhibit", {15'h0, inhibit}, 16'h0000);
        chk("cfg1", cfg1, 16'h0000);
        reg_rd(ADDR_STATUS, got);
        chk("status", got, 16'h0001);
        reg_rd(ADDR_CFG_FIRST, got);
        chk("locked", got, 16'h0000);
        reg_wr(ADDR_MOTOR_DIS, 16'h8000);
        chk("inhibit", {15'h0, inhibit}, 16'h0001);
        reg_rd(ADDR_MOTOR_DIS, got);
        chk("motor_ctrl", got, 16'h0000);
        foreach (holes[i])
        begin
            lfsr_q = lfsr_next(lfsr_q);
            reg_wr(holes[i], lfsr_q);
            reg_rd(holes[i], got);
            chk("unused", got, 16'h0000);
        end
        reg_wr(ADDR_KEY, UNLOCK_KEY);
        lfsr_q = lfsr_next(lfsr_q);
        reg_wr(ADDR_CFG_FIRST, lfsr_q);
        reg_rd(ADDR_CFG_FIRST, got);
        chk("cfg_rw", got, lfsr_q);
        chk("cfg1", cfg1, lfsr_q);
        val = lfsr_next(lfsr_q);
        reg_wr(ADDR_IND_ADDR, 16'h0092);
        reg_wr(ADDR_IND_WDATA, val);
        reg_wr(ADDR_ACC_CTRL, 16'h0005);
        wait_ready();
        chk("mem_92", esp_nvm_model_i.cells[8'h92], val);
        ref_mem[8'h92] = val;
        reg_wr(ADDR_IND_ADDR, 16'h0094);
        for (int k = 0; k < 4; k++)
        begin
            lfsr_q = lfsr_next(lfsr_q);
            delay = lfsr_q[2:0];
            acks = 0;
            reg_wr(ADDR_ACC_CTRL, 16'(k));
            reg_rd(ADDR_STATUS, got);
            chk("busy", got, 16'(ack_exp[k] == 0));
            wait_ready();
            chk("acks", 16'(acks), 16'(ack_exp[k]));
            reg_rd(ADDR_IND_RDATA, got);
            if (k == 1)
                chk("single_rd", got, 16'(ref_mem[8'h94]));
        end
        lfsr_q = lfsr_next(lfsr_q);
        reg_wr(8'h91, lfsr_q);
        ref_mem[8'h91] = lfsr_q;
        acks = 0;
        reg_wr(ADDR_ACC_CTRL, 16'h0006);
        wait_ready();
        chk("acks", 16'(acks), 16'h0007);
        chk("mass_wr", esp_nvm_model_i.cells[8'h91], 16'(ref_mem[8'h91]));
        old = 16'(ref_mem[8'h90]);
        chk("cfg1", cfg1, old);
        val = lfsr_next(lfsr_q);
        esp_nvm_model_i.cells[8'h90] = val;
        acks = 0;
        reg_wr(ADDR_ACC_CTRL, 16'h0100);
        wait_ready();
        chk("acks", 16'(acks), 16'h0007);
        chk("cfg1", cfg1, old);
        reg_wr(ADDR_ACC_CTRL, 16'h1000);
        chk("shadow", {15'h0, shadow}, 16'h0001);
        chk("cfg1", cfg1, val);
        reg_rd(ADDR_CFG_FIRST, got);
        chk("cfg_rd", got, val);
        reg_wr(ADDR_MOTOR_DIS, 16'h0000);
        chk("inhibit", {15'h0, inhibit}, 16'h0000);
        test_done();
    end

endmodule

`default_nettype wire
